// *** flash_timing_defs.svh ***
/*
 * Constants of the flash timing and auto-read register block: register
 * indices, reset values, field positions and timing multipliers.
 * Assumes it is included by bare name from the counter and register modules.
 */
// Behaviour
// [R01] Start delay lasts start_count plus one prescaler clocks; resets to 18h.
// [R02] Transition time lasts transition_count plus one prescaler clocks; resets to 30h.
// [R03] Program pulse lasts 8 times (programming_width plus one); resets to 16h.
// [R04] Page erase pulse lasts 4096 times (page_erase_width plus one); resets to 04h.
// [R05] Module erase pulse lasts 4096 times (module_erase_width plus one); resets to EAh.
// [R06] End delay lasts end_count plus one prescaler clocks; resets to 18h.
// [R07] Module erase end delay lasts 8 times (module_end_count plus one); resets 3Ch.
// [R08] Recovery delay lasts recovery_count plus one prescaler clocks; resets to 04h.
// [R09] Software must not write timing registers while the busy flag is set.
// [R10] Timing registers take reset values at reset only if flash is idle; here they load at every reset, also one applied mid-operation.
// [R11] Function word is sampled at reset into a read-only register.
// [R12] Protection word is sampled at reset and drives protection settings.
// [R13] Each auto-read register has a data-flash alias returning the same value.
// [R14] Code-area word loads during reset and gives the CPU its branch displacement.
// [R15] Code-area address bits 10:0 always read zero.
// [R16] Code-area address bit 15 always reads zero.
// [R17] Code-area bits 14:11 load with the inverted boot-area field at reset.
// [R18] Prescaler clock is system clock divided by prescaler_divisor plus one.
// [R19] Busy flag is set during program or erase, clear when ready.
// [R20] Operation runs start, transition, pulse, end delay, recovery, each reloaded.
`ifndef FLASH_TIMING_DEFS_SVH
`define FLASH_TIMING_DEFS_SVH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define IDX_START_DELAY      4'h0
`define IDX_TRANSITION_TIME  4'h1
`define IDX_PROGRAM_PULSE    4'h2
`define IDX_PAGE_ERASE_PULSE 4'h3
`define IDX_MODULE_ERASE     4'h4
`define IDX_END_DELAY        4'h5
`define IDX_MODULE_END       4'h6
`define IDX_RECOVERY         4'h7
`define IDX_FUNCTION_WORD    4'h8
`define IDX_PROTECTION_WORD  4'h9
`define IDX_CODE_AREA        4'ha
`define IDX_FUNCTION_ALIAS   4'hb
`define IDX_PROTECTION_ALIAS 4'hc
`define IDX_CODE_AREA_ALIAS  4'hd
`define IDX_PRESCALER        4'he

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_START_DELAY      8'h18
`define RST_TRANSITION_TIME  8'h30
`define RST_PROGRAM_PULSE    8'h16
`define RST_PAGE_ERASE_PULSE 8'h04
`define RST_MODULE_ERASE     8'hea
`define RST_END_DELAY        8'h18
`define RST_MODULE_END       8'h3c
`define RST_RECOVERY         8'h04
`define RST_PRESCALER        5'h04

// ------------------------------------------------------------
// Fields and multipliers (log2 of the scale factor)
// ------------------------------------------------------------
`define BOOT_AREA_LSB        0
`define BOOT_AREA_MSB        3
`define CODE_MID_LSB         11
`define CODE_MID_MSB         14
`define SHIFT_X1             5'd0
`define SHIFT_X8             5'd3
`define SHIFT_X4096          5'd12

`endif

// *** flash_timing_pkg.sv ***
/*
 * Types shared by the flash timing block.
 * Assumes flash_timing_defs.svh sits in the same folder.
 */
package flash_timing_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_START   = 3'b001,
        ST_TRANS   = 3'b010,
        ST_PULSE   = 3'b011,
        ST_END     = 3'b100,
        ST_RECOVER = 3'b101
    } phase_t;

    typedef enum logic [1:0] {
        OP_PROGRAM      = 2'b00,
        OP_PAGE_ERASE   = 2'b01,
        OP_MODULE_ERASE = 2'b10
    } op_t;

    // Register access from the CPU bus
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] idx;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// *** flash_phase_counter.sv ***
/*
 * Down counter timing one phase of a flash operation in prescaler clocks.
 * Assumes the caller loads it once per phase and waits for o_done.
 */
`timescale 1ns/1ps
`include "flash_timing_defs.svh"
module flash_phase_counter
    import flash_timing_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    input  wire logic        i_load,
    input  wire logic [7:0]  i_reload,
    input  wire logic [4:0]  i_shift,
    input  wire logic        i_tick,
    output logic             o_done
);
    logic [20:0] count;

    // Total = (reload + 1) << shift ticks; done on the last tick
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count  <= 21'h0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_load) begin
                count <= 21'(({13'h0, i_reload} + 21'h1) << i_shift);
            end else if (i_tick && count != 21'h0) begin
                count <= count - 21'h1;
                if (count == 21'h1) begin
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule

// *** flash_timing_regs.sv ***
/*
 * Flash timing reload registers, prescaler, program/erase sequencer and
 * the auto-read registers captured at reset.
 * Assumes a simple synchronous CPU register port and that the info-block
 * words are stable while the reset is low and at its release.
 */
`timescale 1ns/1ps
`include "flash_timing_defs.svh"
module flash_timing_regs
    import flash_timing_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    input  wire reg_req_t    i_req,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    input  wire logic        i_op_start,
    input  wire op_t         i_op_kind,
    input  wire logic [15:0] i_function_word,
    input  wire logic [15:0] i_protection_word,
    output logic             o_flash_busy_flag,
    output logic [2:0]       o_phase,
    output logic             o_pulse_active,
    output logic             o_write_ignored,
    output logic [15:0]      o_protection,
    output logic [15:0]      o_code_area_start
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]  reload [0:7];
    logic [4:0]  prescaler_divisor;
    logic [15:0] function_word_copy;
    logic [15:0] protection_word_copy;
    logic [15:0] code_area_start;
    logic        captured;
    logic        busy;
    phase_t      phase;
    op_t         op;
    logic [4:0]  pre_count;
    logic        tick;
    logic        load;
    logic [7:0]  cur_reload;
    logic [4:0]  cur_shift;
    logic        phase_done;
    logic        wr_ok;

    function automatic logic [7:0] reset_value(input logic [2:0] idx);
        case (idx)
            3'd0:    reset_value = `RST_START_DELAY;
            3'd1:    reset_value = `RST_TRANSITION_TIME;
            3'd2:    reset_value = `RST_PROGRAM_PULSE;
            3'd3:    reset_value = `RST_PAGE_ERASE_PULSE;
            3'd4:    reset_value = `RST_MODULE_ERASE;
            3'd5:    reset_value = `RST_END_DELAY;
            3'd6:    reset_value = `RST_MODULE_END;
            default: reset_value = `RST_RECOVERY;
        endcase
    endfunction

    // Writes while busy are dropped; software is expected not to try
    assign wr_ok = i_req.wr && !busy;  // see [R09]

    // ------------------------------------------------------------
    // Timing reload registers
    // ------------------------------------------------------------
    // Reset values load at every reset, whether the sequencer is idle or mid-operation;
    // the same reset also returns the sequencer to idle.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_reload
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    reload[g] <= reset_value(3'(g));  // see [R10] [R01] [R02] [R03] [R04] [R05] [R06] [R07] [R08]
                end else if (i_ce && wr_ok && i_req.idx == 4'(g)) begin
                    reload[g] <= i_req.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prescaler_divisor <= `RST_PRESCALER;
        end else if (i_ce && wr_ok && i_req.idx == `IDX_PRESCALER) begin
            prescaler_divisor <= i_req.wdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Auto-read capture
    // ------------------------------------------------------------
    // Caught on the first enabled edge after release; an async reset may
    // only load constants.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            captured             <= 1'b0;
            function_word_copy   <= 16'h0;
            protection_word_copy <= 16'h0;
            code_area_start      <= 16'h0;
        end else if (i_ce && !captured) begin
            captured             <= 1'b1;
            function_word_copy   <= i_function_word;    // see [R11]
            protection_word_copy <= i_protection_word;  // see [R12]
            code_area_start      <= {1'b0,              // see [R16] [R14]
                                     ~i_protection_word[`BOOT_AREA_MSB:`BOOT_AREA_LSB],  // see [R17]
                                     11'h000};          // see [R15]
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pre_count <= 5'h0;
            tick      <= 1'b0;
        end else if (i_ce) begin
            if (pre_count >= prescaler_divisor) begin  // see [R18]
                pre_count <= 5'h0;
                tick      <= 1'b1;
            end else begin
                pre_count <= pre_count + 5'h1;
                tick      <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase selection
    // ------------------------------------------------------------
    always_comb begin
        cur_reload = reload[0];
        cur_shift  = `SHIFT_X1;
        case (phase)
            ST_IDLE: begin
                cur_reload = reload[0];
                cur_shift  = `SHIFT_X1;
            end
            ST_START: begin
                cur_reload = reload[0];  // see [R01]
                cur_shift  = `SHIFT_X1;
            end
            ST_TRANS: begin
                cur_reload = reload[1];  // see [R02]
                cur_shift  = `SHIFT_X1;
            end
            ST_PULSE: begin
                case (op)
                    OP_PROGRAM: begin
                        cur_reload = reload[2];  // see [R03]
                        cur_shift  = `SHIFT_X8;
                    end
                    OP_PAGE_ERASE: begin
                        cur_reload = reload[3];  // see [R04]
                        cur_shift  = `SHIFT_X4096;
                    end
                    default: begin
                        cur_reload = reload[4];  // see [R05]
                        cur_shift  = `SHIFT_X4096;
                    end
                endcase
            end
            ST_END: begin
                if (op == OP_MODULE_ERASE) begin
                    cur_reload = reload[6];  // see [R07]
                    cur_shift  = `SHIFT_X8;
                end else begin
                    cur_reload = reload[5];  // see [R06]
                    cur_shift  = `SHIFT_X1;
                end
            end
            ST_RECOVER: begin
                cur_reload = reload[7];  // see [R08]
                cur_shift  = `SHIFT_X1;
            end
            default: begin
                cur_reload = reload[0];
                cur_shift  = `SHIFT_X1;
            end
        endcase
    end

    flash_phase_counter u_counter (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_ce     (i_ce),
        .i_load   (load),
        .i_reload (cur_reload),
        .i_shift  (cur_shift),
        .i_tick   (tick),
        .o_done   (phase_done)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Load is a one-cycle strobe set on the same edge that enters each phase, so
    // the value selected above belongs to the phase already in force.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= ST_IDLE;
            op    <= OP_PROGRAM;
            load  <= 1'b0;
            busy  <= 1'b0;
        end else if (i_ce) begin
            load <= 1'b0;
            case (phase)
                ST_IDLE: begin
                    if (i_op_start) begin
                        op    <= i_op_kind;
                        phase <= ST_START;  // see [R20]
                        load  <= 1'b1;
                        busy  <= 1'b1;      // see [R19]
                    end
                end
                ST_START, ST_TRANS, ST_PULSE, ST_END: begin
                    if (phase_done) begin
                        phase <= phase_t'(phase + 3'h1);  // see [R20]
                        load  <= 1'b1;
                    end
                end
                ST_RECOVER: begin
                    if (phase_done) begin
                        phase <= ST_IDLE;
                        busy  <= 1'b0;  // see [R19]
                    end
                end
                default: begin
                    phase <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port and registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata  <= 16'h0;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= i_req.rd;
            o_rdata  <= 16'h0;
            if (i_req.rd) begin
                case (i_req.idx)
                    `IDX_START_DELAY, `IDX_TRANSITION_TIME, `IDX_PROGRAM_PULSE,
                    `IDX_PAGE_ERASE_PULSE, `IDX_MODULE_ERASE, `IDX_END_DELAY,
                    `IDX_MODULE_END, `IDX_RECOVERY:
                        o_rdata <= {8'h0, reload[i_req.idx[2:0]]};
                    `IDX_FUNCTION_WORD, `IDX_FUNCTION_ALIAS:
                        o_rdata <= function_word_copy;    // see [R13]
                    `IDX_PROTECTION_WORD, `IDX_PROTECTION_ALIAS:
                        o_rdata <= protection_word_copy;  // see [R13]
                    `IDX_CODE_AREA, `IDX_CODE_AREA_ALIAS:
                        o_rdata <= code_area_start;       // see [R13]
                    `IDX_PRESCALER:
                        o_rdata <= {11'h0, prescaler_divisor};
                    default:
                        o_rdata <= 16'h0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_flash_busy_flag <= 1'b0;
            o_phase           <= 3'h0;
            o_pulse_active    <= 1'b0;
            o_write_ignored   <= 1'b0;
            o_protection      <= 16'h0;
            o_code_area_start <= 16'h0;
        end else if (i_ce) begin
            o_flash_busy_flag <= busy;
            o_phase           <= phase;
            o_pulse_active    <= (phase == ST_TRANS) && !phase_done ? 1'b0 : (phase == ST_PULSE);
            o_write_ignored   <= i_req.wr && busy;
            o_protection      <= protection_word_copy;  // see [R12]
            o_code_area_start <= code_area_start;       // see [R14]
        end
    end
endmodule

// *** flash_timing_regs_monitor.sv ***
/*
 * Port-level checker for the flash timing and auto-read register block.
 * Assumes the info-block words stay stable after reset.
 */
`timescale 1ns/1ps
module flash_timing_regs_monitor
    import flash_timing_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    input  wire reg_req_t    i_req,
    input  wire logic [15:0] o_rdata,
    input  wire logic        o_rvalid,
    input  wire logic        i_op_start,
    input  wire op_t         i_op_kind,
    input  wire logic [15:0] i_function_word,
    input  wire logic [15:0] i_protection_word,
    input  wire logic        o_flash_busy_flag,
    input  wire logic [2:0]  o_phase,
    input  wire logic        o_pulse_active,
    input  wire logic        o_write_ignored,
    input  wire logic [15:0] o_protection,
    input  wire logic [15:0] o_code_area_start
);
    // ------------------------------------------------------------
    // Edges since reset release; copies settle after two of them
    // ------------------------------------------------------------
    logic [1:0] since;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since <= 2'h0;
        end else if (i_ce && since != 2'h3) begin
            since <= since + 2'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_code_top; o_code_area_start[15] == 1'b0; endproperty
    a_code_top: assert property (p_code_top) else $error("code area bit 15 set");
    property p_code_low; o_code_area_start[10:0] == 11'h0; endproperty
    a_code_low: assert property (p_code_low) else $error("code area low bits set");
    property p_code_mid; since == 2'h3 |-> o_code_area_start[14:11] == ~o_protection[3:0]; endproperty
    a_code_mid: assert property (p_code_mid) else $error("code area mid bits wrong");
    property p_prot; since == 2'h3 |-> o_protection == i_protection_word; endproperty
    a_prot: assert property (p_prot) else $error("protection copy wrong");
    property p_order;
        o_phase != $past(o_phase) |-> o_phase == (($past(o_phase) == 3'h5) ? 3'h0 : $past(o_phase) + 3'h1);
    endproperty
    a_order: assert property (p_order) else $error("phase out of order");
    property p_pulse; o_pulse_active == (o_phase == 3'h3); endproperty
    a_pulse: assert property (p_pulse) else $error("pulse flag mismatch");
    property p_busy_rise; i_op_start && i_ce && o_phase == 3'h0 && !o_flash_busy_flag |-> ##2 o_flash_busy_flag;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
    property p_busy_hold; o_phase inside {[3'h2:3'h5]} |-> o_flash_busy_flag; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy low in operation");
    property p_ignored; i_req.wr && i_ce && o_phase inside {[3'h2:3'h4]} |=> o_write_ignored; endproperty
    a_ignored: assert property (p_ignored) else $error("busy write not dropped");
    property p_rd; i_req.rd && i_ce |=> o_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_unmapped; i_req.rd && i_ce && i_req.idx == 4'hf |=> o_rdata == 16'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind flash_timing_regs flash_timing_regs_monitor i_flash_timing_regs_monitor (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_op_start(i_op_start), .i_op_kind(i_op_kind), .i_function_word(i_function_word),
    .i_protection_word(i_protection_word), .o_flash_busy_flag(o_flash_busy_flag), .o_phase(o_phase),
    .o_pulse_active(o_pulse_active), .o_write_ignored(o_write_ignored), .o_protection(o_protection),
    .o_code_area_start(o_code_area_start));

// *** flash_timing_regs_bench.sv ***
/*
 * Self-checking bench for flash_timing_regs.
 * Assumes the 40 MHz clock and short reload values to keep erase runs brief.
 */
`timescale 1ns/1ps
module flash_timing_regs_bench;
    import flash_timing_pkg::*;
    logic        clk;
    logic        arst_n;
    reg_req_t    req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        op_start;
    op_t         op_kind;
    logic        busy;
    logic [2:0]  phase;
    logic        ign;
    logic        ce;
    logic        pulse;
    logic [15:0] prot;
    logic [15:0] code;
    int          fail_count;
    int          checks;
    int          cnt [8];
    localparam logic [15:0] FW = 16'hc3a5;
    localparam logic [15:0] PW = 16'h5a3c;
    localparam logic [15:0] CA = 16'h1800;

    flash_timing_regs i_flash_timing_regs (
        .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_op_start(op_start), .i_op_kind(op_kind), .i_function_word(FW), .i_protection_word(PW),
        .o_flash_busy_flag(busy), .o_phase(phase), .o_pulse_active(pulse), .o_write_ignored(ign),
        .o_protection(prot), .o_code_area_start(code));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        checks++;
        if (got < exp - 2 || got > exp + 4) begin
            fail_count++;
            $display("CHECK FAILED at %0t: phase took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    task automatic timeout();
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        close_out();
    endtask
    // Idle cycle at the end so back-to-back calls never retoggle a strobe in one step
    task automatic reg_rd(input logic [3:0] idx, input logic [15:0] exp);
        req.rd = 1'b1;
        req.idx = idx;
        @(negedge clk);
        req.rd = 1'b0;
        check({15'h0, rvalid}, 16'h1);
        check(rdata, exp);
        @(negedge clk);
    endtask
    task automatic reg_wr(input logic [3:0] idx, input logic [7:0] data, output logic dropped);
        req.wr = 1'b1;
        req.idx = idx;
        req.wdata = data;
        @(negedge clk);
        req.wr = 1'b0;
        dropped = ign;
        @(negedge clk);
    endtask
    task automatic wait_phase(input logic [2:0] p);
        int n;
        for (n = 0; n < 20000 && phase !== p; n++)
            @(negedge clk);
        if (n == 20000) timeout();
    endtask
    task automatic start(input op_t k);
        op_kind = k;
        op_start = 1'b1;
        @(negedge clk);
        op_start = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals();
        logic [7:0] rst [8] = '{8'h18, 8'h30, 8'h16, 8'h04, 8'hea, 8'h18, 8'h3c, 8'h04};
        for (int i = 0; i < 8; i++)
            reg_rd(4'(i), {8'h0, rst[i]});
        reg_rd(4'he, 16'h0004);
    endtask
    task automatic t_autoread();
        logic d;
        for (int k = 0; k < 2; k++) begin
            reg_rd(4'(8 + 3 * k), FW);
            reg_rd(4'(9 + 3 * k), PW);
            reg_rd(4'(10 + 3 * k), CA);
        end
        for (int i = 8; i < 11; i++)
            reg_wr(4'(i), 8'h00, d);
        reg_rd(4'h8, FW);
        reg_rd(4'h9, PW);
        reg_rd(4'ha, CA);
        reg_rd(4'hf, 16'h0000);
        check(prot, PW);
        check(code, CA);
    endtask
    task automatic t_write_back();
        logic [7:0] tv [8] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
        logic d;
        for (int i = 0; i < 8; i++)
            reg_wr(4'(i), tv[i], d);
        reg_wr(4'he, 8'h01, d);
        for (int i = 0; i < 8; i++)
            reg_rd(4'(i), {8'h0, tv[i]});
        reg_rd(4'he, 16'h0001);
    endtask
    // Clock enable low: a write must not land
    task automatic t_freeze();
        logic d;
        ce = 1'b0;
        reg_wr(4'h0, 8'h55, d);
        ce = 1'b1;
        check({15'h0, d}, 16'h0);
        reg_rd(4'h0, 16'h0002);
    endtask
    // Divisor 1 (tick every 2 clocks): start 6, transition 4, end 4 (16 for module erase), recovery 6 system clocks
    task automatic t_op(input op_t k, input int pulse_exp, input int end_exp);
        int n;
        cnt = '{default: 0};
        start(k);
        for (n = 0; n < 20000 && !(phase == 3'h0 && busy === 1'b0 && cnt[5] > 0); n++) begin
            cnt[phase]++;
            @(negedge clk);
        end
        if (n == 20000) timeout();
        near(cnt[1], 6);
        near(cnt[2], 4);
        near(cnt[3], pulse_exp);
        near(cnt[4], end_exp);
        near(cnt[5], 6);
    endtask
    task automatic t_busy_refuse();
        logic d;
        start(OP_PROGRAM);
        wait_phase(3'h3);
        check({14'h0, pulse, busy}, 16'h3);
        reg_wr(4'h0, 8'h77, d);
        check({15'h0, d}, 16'h1);
        start(OP_MODULE_ERASE);
        wait_phase(3'h0);
        repeat (4) @(negedge clk);
        check({15'h0, busy}, 16'h0);
        reg_rd(4'h0, 16'h0002);
    endtask
    task automatic t_reset_mid();
        start(OP_MODULE_ERASE);
        wait_phase(3'h3);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check({11'h0, pulse, busy, phase}, 16'h0);
        reg_rd(4'h0, 16'h0018);
        reg_rd(4'h4, 16'h00ea);
        reg_rd(4'ha, CA);
    endtask

    initial begin
        fail_count = 0;
        checks = 0;
        arst_n = 1'b0;
        req = '0;
        op_start = 1'b0;
        op_kind = OP_PROGRAM;
        ce = 1'b1;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        t_reset_vals();
        t_autoread();
        t_write_back();
        t_freeze();
        t_op(OP_PROGRAM, 16, 4);
        t_op(OP_PAGE_ERASE, 8192, 4);
        t_op(OP_MODULE_ERASE, 8192, 16);
        t_busy_refuse();
        t_reset_mid();
        close_out();
    end
endmodule
